/* scr_fast_decode.sv */
`timescale 1ns/1ns
module scr_fast_decode #(
	parameter int LEVELS = 8,
	parameter int LEVEL_W = 3
) (
	input wire logic [LEVEL_W-1:0] level_i,
	input wire logic enable_i,
	output logic [LEVELS-1:0] fast_o
);
	// one-hot, at most one level at a time
	always_comb begin
		fast_o = '0;
		if (enable_i) begin
			fast_o[level_i] = 1'b1;
		end
	end
endmodule

/* scr_pkg.sv */
package scr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SP_W = 16;
	localparam int LEVELS = 8;
	localparam int LEVEL_W = 3;

	localparam logic [ADDR_W-1:0] ADDR_STACK_POINTER_HIGH = 8'hd8;
	localparam logic [ADDR_W-1:0] ADDR_STACK_POINTER_LOW = 8'hd9;
	localparam logic [ADDR_W-1:0] ADDR_STOP_GUARD = 8'hdc;
	localparam logic [ADDR_W-1:0] ADDR_SYSTEM_MODE = 8'hde;

	localparam logic [DATA_W-1:0] STOP_GUARD_MAGIC = 8'ha5;
	localparam logic [DATA_W-1:0] STOP_GUARD_RESET = 8'h00;

	localparam int SYM_SPARE_BIT = 7;
	localparam int SYM_LEVEL_LSB = 2;
	localparam int SYM_LEVEL_MSB = 4;
	localparam int SYM_FAST_EN_BIT = 1;
	localparam int SYM_GLOBAL_EN_BIT = 0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic rd;
		logic direct;
		logic [DATA_W-1:0] wdata;
	} scr_req_t;

	typedef struct packed {
		logic stop_enter;
		logic stop_reset;
	} scr_stop_t;

endpackage

/* scr_system_control.sv */
`timescale 1ns/1ns
// How it works
// - high stack pointer byte holds stack bits 15..8, read and write.
// - low stack pointer byte holds stack bits 7..0, read and write.
// - high stack pointer byte sits at register address d8.
// - reset leaves both stack pointer bytes untouched.
// - stop permitted only while guard holds 10100101.
// - any other guard value means stop is disabled.
// - stop without the pattern is refused and raises a reset.
// - low pointer, guard and mode reachable by direct addressing only.
// - fast enable applies fast handling to the selected level only.
// - only one level is ever marked for fast handling.
module scr_system_control
	import scr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire scr_pkg::scr_req_t req_i,
	output logic [scr_pkg::DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	input wire logic sp_load_i,
	input wire logic [scr_pkg::SP_W-1:0] sp_load_data_i,
	output logic [scr_pkg::SP_W-1:0] sp_o,
	input wire logic stop_exec_i,
	output scr_pkg::scr_stop_t stop_o,
	input wire logic enable_interrupts_instruction_i,
	output logic global_int_en_o,
	output logic [scr_pkg::LEVELS-1:0] fast_irq_o
);
	import scr_pkg::*;

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic [DATA_W-1:0] stack_pointer_high_reg;
	logic [DATA_W-1:0] stack_pointer_low_reg;
	logic [DATA_W-1:0] stop_guard_reg;
	logic sym_spare_reg;
	logic [LEVEL_W-1:0] sym_level_reg;
	logic sym_fast_en_reg;
	logic sym_global_en_reg;
	logic [DATA_W-1:0] rdata_next;
	logic stop_allowed;

	function automatic logic hit(input scr_req_t r, input logic [ADDR_W-1:0] a,
		input logic direct_only);
		hit = (r.addr == a) && (r.direct || !direct_only);
	endfunction

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// stack pointer bytes carry no reset
	always_ff @(posedge clk_i) begin
		if (sp_load_i) begin
			stack_pointer_high_reg <= sp_load_data_i[SP_W-1:DATA_W];
		end else if (req_i.wr && hit(req_i, ADDR_STACK_POINTER_HIGH, 1'b0)) begin
			stack_pointer_high_reg <= req_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sp_load_i) begin
			stack_pointer_low_reg <= sp_load_data_i[DATA_W-1:0];
		end else if (req_i.wr && hit(req_i, ADDR_STACK_POINTER_LOW, 1'b1)) begin
			stack_pointer_low_reg <= req_i.wdata;
		end
	end

	assign sp_o = {stack_pointer_high_reg, stack_pointer_low_reg};

	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			stop_guard_reg <= STOP_GUARD_RESET;
		end else if (req_i.wr && hit(req_i, ADDR_STOP_GUARD, 1'b1)) begin
			stop_guard_reg <= req_i.wdata;
		end
	end

	assign stop_allowed = (stop_guard_reg == STOP_GUARD_MAGIC);

	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			stop_o <= '0;
		end else begin
			stop_o.stop_enter <= stop_exec_i && stop_allowed;
			stop_o.stop_reset <= stop_exec_i && !stop_allowed;
		end
	end

	// enable bits and spare bit: cleared by reset
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sym_spare_reg <= 1'b0;
			sym_fast_en_reg <= 1'b0;
			sym_global_en_reg <= 1'b0;
		end else begin
			if (req_i.wr && hit(req_i, ADDR_SYSTEM_MODE, 1'b1)) begin
				sym_spare_reg <= req_i.wdata[SYM_SPARE_BIT];
				sym_fast_en_reg <= req_i.wdata[SYM_FAST_EN_BIT];
				sym_global_en_reg <= req_i.wdata[SYM_GLOBAL_EN_BIT];
			end
			if (enable_interrupts_instruction_i) begin
				sym_global_en_reg <= 1'b1;
			end
		end
	end

	// level field has no reset value
	always_ff @(posedge clk_i) begin
		if (req_i.wr && hit(req_i, ADDR_SYSTEM_MODE, 1'b1)) begin
			sym_level_reg <= req_i.wdata[SYM_LEVEL_MSB:SYM_LEVEL_LSB];
		end
	end

	assign global_int_en_o = sym_global_en_reg;

	scr_fast_decode #(
		.LEVELS(LEVELS),
		.LEVEL_W(LEVEL_W)
	) scr_fast_decode_inst (
		.level_i(sym_level_reg),
		.enable_i(sym_fast_en_reg),
		.fast_o(fast_irq_o)
	);

	always_comb begin
		rdata_next = '0;
		if (hit(req_i, ADDR_STACK_POINTER_HIGH, 1'b0)) begin
			rdata_next = stack_pointer_high_reg;
		end else if (hit(req_i, ADDR_STACK_POINTER_LOW, 1'b1)) begin
			rdata_next = stack_pointer_low_reg;
		end else if (hit(req_i, ADDR_STOP_GUARD, 1'b1)) begin
			rdata_next = stop_guard_reg;
		end else if (hit(req_i, ADDR_SYSTEM_MODE, 1'b1)) begin
			rdata_next[SYM_SPARE_BIT] = sym_spare_reg;
			rdata_next[SYM_LEVEL_MSB:SYM_LEVEL_LSB] = sym_level_reg;
			rdata_next[SYM_FAST_EN_BIT] = sym_fast_en_reg;
			rdata_next[SYM_GLOBAL_EN_BIT] = sym_global_en_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (req_i.rd) begin
				rdata_o <= rdata_next;
			end
		end
	end

	chk_sph_write: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		req_i.wr && req_i.addr == ADDR_STACK_POINTER_HIGH && !sp_load_i
		|=> sp_o[SP_W-1:DATA_W] == $past(req_i.wdata))
		else $error("high stack byte not written");

	chk_spl_write: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		req_i.wr && req_i.direct && req_i.addr == ADDR_STACK_POINTER_LOW && !sp_load_i
		|=> sp_o[DATA_W-1:0] == $past(req_i.wdata))
		else $error("low stack byte not written");

	chk_sph_read_back: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		req_i.rd && req_i.addr == ADDR_STACK_POINTER_HIGH
		|=> rvalid_o && rdata_o == $past(sp_o[SP_W-1:DATA_W]))
		else $error("high stack byte read wrong");

	chk_indirect_ignored: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		req_i.wr && !req_i.direct && req_i.addr == ADDR_STOP_GUARD
		|=> $stable(stop_guard_reg))
		else $error("indirect write reached guard");

	chk_stop_granted: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		stop_exec_i && stop_guard_reg == STOP_GUARD_MAGIC
		|=> stop_o.stop_enter && !stop_o.stop_reset)
		else $error("stop not granted with pattern");

	chk_stop_refused: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		stop_exec_i && stop_guard_reg != STOP_GUARD_MAGIC
		|=> stop_o.stop_reset && !stop_o.stop_enter)
		else $error("stop not refused without pattern");

	chk_stop_quiet: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		!stop_exec_i |=> !stop_o.stop_enter && !stop_o.stop_reset)
		else $error("stop pulse without request");

	chk_fast_level: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		req_i.wr && req_i.direct && req_i.addr == ADDR_SYSTEM_MODE
		&& req_i.wdata[SYM_FAST_EN_BIT]
		|=> fast_irq_o == (LEVELS'(1) << $past(req_i.wdata[SYM_LEVEL_MSB:SYM_LEVEL_LSB])))
		else $error("fast level mismatch");

	chk_fast_onehot: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		$onehot0(fast_irq_o) && (sym_fast_en_reg || fast_irq_o == '0))
		else $error("more than one fast level");

	chk_reset_clears: assert property (@(posedge clk_i)
		$rose(rst_sync_reg) |-> !global_int_en_o && fast_irq_o == '0)
		else $error("enables not cleared by reset");

	chk_ei_sets: assert property (@(posedge clk_i) disable iff (!rst_sync_reg)
		enable_interrupts_instruction_i |=> global_int_en_o)
		else $error("enable instruction ignored");

endmodule

/* scr_system_control_tb.sv */
`timescale 1ns/1ns
module scr_system_control_tb;
	import scr_pkg::*;
	logic clk_i, rst_n_i, sp_load_i, stop_exec_i, ei_i, rvalid_o, global_int_en_o;
	scr_req_t req_i;
	logic [SP_W-1:0] sp_load_data_i, sp_o;
	logic [DATA_W-1:0] rdata_o;
	scr_stop_t stop_o;
	logic [LEVELS-1:0] fast_irq_o;
	int err_total = 0;
	int num_checks = 0;
	scr_system_control scr_system_control_inst (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.req_i(req_i),
		.rdata_o(rdata_o),
		.rvalid_o(rvalid_o),
		.sp_load_i(sp_load_i),
		.sp_load_data_i(sp_load_data_i),
		.sp_o(sp_o),
		.stop_exec_i(stop_exec_i),
		.stop_o(stop_o),
		.enable_interrupts_instruction_i(ei_i),
		.global_int_en_o(global_int_en_o),
		.fast_irq_o(fast_irq_o)
	);
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dir);
		@(negedge clk_i);
		req_i = '{addr: a, wr: 1'b1, rd: 1'b0, direct: dir, wdata: d};
		@(negedge clk_i);
		req_i.wr = 1'b0;
	endtask
	// read strobe taken at one edge, answer stands in the following cycle
	task automatic rd(input logic [7:0] a, input logic dir, input logic [7:0] exp);
		@(negedge clk_i);
		req_i = '{addr: a, wr: 1'b0, rd: 1'b1, direct: dir, wdata: 8'h00};
		@(negedge clk_i);
		check(16'(rvalid_o), 16'h0001);
		check(16'(rdata_o), 16'(exp));
		req_i.rd = 1'b0;
	endtask
	task automatic stp(input logic [1:0] exp);
		@(negedge clk_i);
		check(16'(stop_o), 16'h0000);
		stop_exec_i = 1'b1;
		@(negedge clk_i);
		check(16'(stop_o), 16'(exp));
		stop_exec_i = 1'b0;
	endtask
	initial begin
		rst_n_i = 1'b0;
		req_i = '0;
		sp_load_i = 1'b0;
		sp_load_data_i = '0;
		stop_exec_i = 1'b0;
		ei_i = 1'b0;
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		check(16'(global_int_en_o), 16'h0000);
		check(16'(fast_irq_o), 16'h0000);
		rd(ADDR_STOP_GUARD, 1'b1, STOP_GUARD_RESET);
		stp(2'b01);
		wr(ADDR_STOP_GUARD, 8'ha5, 1'b1);
		stp(2'b10);
		stp(2'b10);
		wr(ADDR_STOP_GUARD, 8'ha4, 1'b1);
		stp(2'b01);
		wr(ADDR_STOP_GUARD, 8'ha5, 1'b0);
		stp(2'b01);
		wr(8'hd8, 8'h3c, 1'b0);
		wr(ADDR_STACK_POINTER_LOW, 8'hc3, 1'b1);
		check(sp_o, 16'h3cc3);
		rd(8'hd8, 1'b1, 8'h3c);
		rd(ADDR_STACK_POINTER_LOW, 1'b1, 8'hc3);
		wr(ADDR_STACK_POINTER_LOW, 8'h55, 1'b0);
		rd(ADDR_STACK_POINTER_LOW, 1'b0, 8'h00);
		check(sp_o, 16'h3cc3);
		@(negedge clk_i);
		sp_load_i = 1'b1;
		sp_load_data_i = 16'h8001;
		@(negedge clk_i);
		sp_load_i = 1'b0;
		check(sp_o, 16'h8001);
		for (int l = 0; l < LEVELS; l++) begin
			wr(ADDR_SYSTEM_MODE, {3'b000, 3'(l), 2'b10}, 1'b1);
			check(16'(fast_irq_o), 16'(8'h01 << l));
		end
		rd(ADDR_SYSTEM_MODE, 1'b1, 8'h1e);
		wr(ADDR_SYSTEM_MODE, 8'h1c, 1'b1);
		check(16'(fast_irq_o), 16'h0000);
		check(16'(global_int_en_o), 16'h0000);
		@(negedge clk_i);
		ei_i = 1'b1;
		@(negedge clk_i);
		ei_i = 1'b0;
		check(16'(global_int_en_o), 16'h0001);
		wr(ADDR_SYSTEM_MODE, 8'h00, 1'b0);
		check(16'(global_int_en_o), 16'h0001);
		// enable instruction wins over a same-cycle mode write
		@(negedge clk_i);
		req_i = '{addr: ADDR_SYSTEM_MODE, wr: 1'b1, rd: 1'b0, direct: 1'b1, wdata: 8'h0a};
		ei_i = 1'b1;
		@(negedge clk_i);
		req_i.wr = 1'b0;
		ei_i = 1'b0;
		check(16'(global_int_en_o), 16'h0001);
		check(16'(fast_irq_o), 16'h0004);
		// second reset in mid-run
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		check(16'(global_int_en_o), 16'h0000);
		check(16'(fast_irq_o), 16'h0000);
		check(sp_o, 16'h8001);
		rd(ADDR_STOP_GUARD, 1'b1, STOP_GUARD_RESET);
		stp(2'b01);
		conclude();
	end
	// whole sequence needs about 76 cycles
	initial begin
		#30000;
		err_total++;
		conclude();
	end
endmodule
